//--- src/pmd_device.sv
`timescale 1ns/1ps
// Summary of operation
// - Linear 5/11: exponent b15..11, mantissa b10..0
// - Linear 16u: unsigned mantissa, fixed exponent -12
// - Integer word: plain unsigned 16 bits
// - Unpublished reads never disturb device state
// - Writing unpublished read-only code sets fault bit6
// - Host never writes unpublished command codes
// - Code 0xEA saves fault log to NVM
// - Code 0xEC erases NVM fault log block
// - Code 0xF0 compares commands with NVM copies
// - Code 0xFD performs full reset, no power cycle
// - Store/restore only touch nonvolatile commands
// - Code 0xE7 returns fixed identity word
// - Code 0xF4 returns peak die temperature
// - Per-channel input current offset, default 0x9333
// - Code 0xED returns per-channel input current
// - Per-channel rail address byte, default 0x80
// - Mode bit7 selects current-limit gain range; only the channel 0 mode byte drives it
// - Mode bit1 selects output voltage range; only the channel 0 mode byte drives it
// - Per-channel ext temp offset, default 0x8000
// - Per-channel ext temp slope, default 0x4000
// - Per-channel sense coefficient, default 3900, saved
// - Unpaged controller config, default 0x10, saved
// - Peak clear resets all peaks incl. die
module pmd_device #(
   parameter logic [15:0] IDENTITY = 16'h5a5a, // arbitrary value
   parameter int          NCH      = 2,
   parameter int          LOG_BYTES = 16
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Link
   pmd_link_if.device       link,
   // Telemetry
   input  wire logic        die_temp_valid,
   input  wire logic [15:0] die_temp,
   input  wire logic [15:0] iin_raw_ch0,
   input  wire logic [15:0] iin_raw_ch1,
   input  wire logic [7:0]  fault_ram_byte,
   // Loop and NVM controls
   output logic             ilim_high_range,
   output logic             vout_high_range,
   output logic             cml_fault,
   output logic             log_saved,
   output logic             log_erased,
   output logic             nvm_mismatch,
   output logic             reset_pulse
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] iin_ofs0, iin_ofs1, tc0, tc1;
      logic [15:0] slope0, slope1, tofs0, tofs1;
      logic [7:0]  rail0, rail1, mode0, mode1;
      logic [7:0]  cfg;
      logic        page;
      logic [7:0]  status;
      logic [7:0]  log_ptr;
      logic        saved, erased, mismatch, rst_req;
      logic        ack;
      logic [15:0] rdata;
   } pmd_dev_t;
   // Nonvolatile copies: paged words, paged bytes, then config
   typedef struct packed {
      logic [15:0] iin_ofs0, iin_ofs1, tc0, tc1;
      logic [15:0] slope0, slope1, tofs0, tofs1;
      logic [7:0]  rail0, rail1, mode0, mode1;
      logic [7:0]  cfg;
   } pmd_nvm_t;
   pmd_dev_t s_q, s_d;
   pmd_nvm_t nvm_q, nvm_d, live;
   logic [7:0] flog_q [LOG_BYTES];
   logic [15:0] die_peak;
   logic        clr_peaks, take, wr, sb;
   logic [15:0] iin_sel;
   assign take = link.req && !s_q.ack;
   assign wr   = take && link.kind == pmd_pkg::KIND_WRITE;
   assign sb   = take && link.kind == pmd_pkg::KIND_SEND;
   assign clr_peaks = sb && link.code == pmd_pkg::CMD_PEAK_CLEAR;
   pmd_peak u_peak (
      .core_clk     (core_clk),
      .rst          (rst),
      .ce           (ce),
      .sample_valid (die_temp_valid),
      .sample       (die_temp),
      .clear        (clr_peaks || s_q.rst_req),
      .peak_q       (die_peak)
   );
   always_comb begin
      live = '{s_q.iin_ofs0, s_q.iin_ofs1, s_q.tc0, s_q.tc1, s_q.slope0,
               s_q.slope1, s_q.tofs0, s_q.tofs1, s_q.rail0, s_q.rail1,
               s_q.mode0, s_q.mode1, s_q.cfg};
   end
   // Current plus quiescent offset, both linear 5/11 with same exponent
   always_comb begin
      iin_sel = s_q.page ? iin_raw_ch1 : iin_raw_ch0;
      iin_sel[pmd_pkg::L11_MAN_MSB:0] = iin_sel[pmd_pkg::L11_MAN_MSB:0] +
         (s_q.page ? s_q.iin_ofs1[pmd_pkg::L11_MAN_MSB:0]
                   : s_q.iin_ofs0[pmd_pkg::L11_MAN_MSB:0]);
   end
   always_comb begin
      s_d = s_q;
      nvm_d = nvm_q;
      s_d.ack = take;
      if (wr) begin
         // Writable codes other than page and config land in the selected channel copy
         if (link.code == pmd_pkg::CMD_PAGE) begin
            s_d.page = link.wdata[0];
         end else if (link.code == pmd_pkg::CMD_IIN_OFFSET) begin
            if (s_q.page) s_d.iin_ofs1 = link.wdata;
            else s_d.iin_ofs0 = link.wdata;
         end else if (link.code == pmd_pkg::CMD_SENSE_TC) begin
            if (s_q.page) s_d.tc1 = link.wdata;
            else s_d.tc0 = link.wdata;
         end else if (link.code == pmd_pkg::CMD_EXT_SLOPE) begin
            if (s_q.page) s_d.slope1 = link.wdata;
            else s_d.slope0 = link.wdata;
         end else if (link.code == pmd_pkg::CMD_EXT_OFFSET) begin
            if (s_q.page) s_d.tofs1 = link.wdata;
            else s_d.tofs0 = link.wdata;
         end else if (link.code == pmd_pkg::CMD_RAIL_ADDR) begin
            if (s_q.page) s_d.rail1 = link.wdata[7:0];
            else s_d.rail0 = link.wdata[7:0];
         end else if (link.code == pmd_pkg::CMD_PWM_MODE) begin
            if (s_q.page) s_d.mode1 = link.wdata[7:0];
            else s_d.mode0 = link.wdata[7:0];
         end else if (link.code == pmd_pkg::CMD_CTRL_CONFIG) begin
            s_d.cfg = link.wdata[7:0];
         end else begin
            // Read-only or unpublished: no state moves, only the fault
            s_d.status[pmd_pkg::CML_FAULT_BIT] = 1'b1;
         end
      end
      if (sb) begin
         case (link.code)
            pmd_pkg::CMD_FLOG_SAVE: begin
               s_d.saved = 1'b1;
               s_d.erased = 1'b0;
            end
            pmd_pkg::CMD_FLOG_ERASE: begin
               s_d.erased = 1'b1;
               s_d.saved = 1'b0;
               s_d.log_ptr = '0;
            end
            pmd_pkg::CMD_NVM_COMPARE: s_d.mismatch = (live != nvm_q);
            pmd_pkg::CMD_STORE_ALL:   nvm_d = live;
            pmd_pkg::CMD_RESTORE_ALL: begin
               {s_d.iin_ofs0, s_d.iin_ofs1, s_d.tc0, s_d.tc1, s_d.slope0,
                s_d.slope1, s_d.tofs0, s_d.tofs1, s_d.rail0, s_d.rail1,
                s_d.mode0, s_d.mode1, s_d.cfg} = nvm_q;
            end
            pmd_pkg::CMD_SOFT_RESET:  s_d.rst_req = 1'b1;
            default: ;
         endcase
      end
      if (take && link.kind == pmd_pkg::KIND_READ) begin
         // Reads select data, log byte reads also advance log_ptr; unknown codes return zero
         s_d.rdata = '0;
         if (link.code == pmd_pkg::CMD_IDENTITY) s_d.rdata = IDENTITY;
         else if (link.code == pmd_pkg::CMD_PAGE) s_d.rdata = {15'h0, s_q.page};
         else if (link.code == pmd_pkg::CMD_IIN_OFFSET)
            s_d.rdata = s_q.page ? s_q.iin_ofs1 : s_q.iin_ofs0;
         else if (link.code == pmd_pkg::CMD_CHAN_IIN) s_d.rdata = iin_sel;
         else if (link.code == pmd_pkg::CMD_FLOG_BYTES) begin
            s_d.rdata = {8'h00, flog_q[s_q.log_ptr[$clog2(LOG_BYTES)-1:0]]};
            s_d.log_ptr = s_q.log_ptr + 8'h01;
         end
         else if (link.code == pmd_pkg::CMD_SHARED_STATUS)
            s_d.rdata = {8'h00, s_q.status};
         else if (link.code == pmd_pkg::CMD_DIE_PEAK) s_d.rdata = die_peak;
         else if (link.code == pmd_pkg::CMD_CTRL_CONFIG) s_d.rdata = {8'h00, s_q.cfg};
         else if (link.code == pmd_pkg::CMD_SENSE_TC)
            s_d.rdata = s_q.page ? s_q.tc1 : s_q.tc0;
         else if (link.code == pmd_pkg::CMD_EXT_SLOPE)
            s_d.rdata = s_q.page ? s_q.slope1 : s_q.slope0;
         else if (link.code == pmd_pkg::CMD_EXT_OFFSET)
            s_d.rdata = s_q.page ? s_q.tofs1 : s_q.tofs0;
         else if (link.code == pmd_pkg::CMD_RAIL_ADDR)
            s_d.rdata = {8'h00, s_q.page ? s_q.rail1 : s_q.rail0};
         else if (link.code == pmd_pkg::CMD_PWM_MODE)
            s_d.rdata = {8'h00, s_q.page ? s_q.mode1 : s_q.mode0};
      end
      if (s_q.rst_req) begin
         // Commanded reset: reload nonvolatile set, clear volatile state
         s_d = '0;
         s_d.rdata = s_q.rdata; // Read data holds until the next read
         {s_d.iin_ofs0, s_d.iin_ofs1, s_d.tc0, s_d.tc1, s_d.slope0,
          s_d.slope1, s_d.tofs0, s_d.tofs1, s_d.rail0, s_d.rail1,
          s_d.mode0, s_d.mode1, s_d.cfg} = nvm_q;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.iin_ofs0 <= pmd_pkg::RST_IIN_OFFSET;
         s_q.iin_ofs1 <= pmd_pkg::RST_IIN_OFFSET;
         s_q.tc0 <= pmd_pkg::RST_SENSE_TC;
         s_q.tc1 <= pmd_pkg::RST_SENSE_TC;
         s_q.slope0 <= pmd_pkg::RST_EXT_SLOPE;
         s_q.slope1 <= pmd_pkg::RST_EXT_SLOPE;
         s_q.tofs0 <= pmd_pkg::RST_EXT_OFFSET;
         s_q.tofs1 <= pmd_pkg::RST_EXT_OFFSET;
         s_q.rail0 <= pmd_pkg::RST_RAIL_ADDR;
         s_q.rail1 <= pmd_pkg::RST_RAIL_ADDR;
         s_q.mode0 <= pmd_pkg::RST_PWM_MODE;
         s_q.mode1 <= pmd_pkg::RST_PWM_MODE;
         s_q.cfg <= pmd_pkg::RST_CTRL_CONFIG;
         nvm_q <= '{pmd_pkg::RST_IIN_OFFSET, pmd_pkg::RST_IIN_OFFSET,
                    pmd_pkg::RST_SENSE_TC, pmd_pkg::RST_SENSE_TC,
                    pmd_pkg::RST_EXT_SLOPE, pmd_pkg::RST_EXT_SLOPE,
                    pmd_pkg::RST_EXT_OFFSET, pmd_pkg::RST_EXT_OFFSET,
                    pmd_pkg::RST_RAIL_ADDR, pmd_pkg::RST_RAIL_ADDR,
                    pmd_pkg::RST_PWM_MODE, pmd_pkg::RST_PWM_MODE,
                    pmd_pkg::RST_CTRL_CONFIG};
      end else if (ce) begin
         s_q <= s_d;
         nvm_q <= nvm_d;
      end
   end
   // Fault log image: snapshot of RAM byte per save
   always_ff @(posedge core_clk) begin
      if (ce && sb && link.code == pmd_pkg::CMD_FLOG_SAVE) begin
         for (int i = LOG_BYTES - 1; i > 0; i--) flog_q[i] <= flog_q[i-1];
         flog_q[0] <= fault_ram_byte;
      end else if (ce && sb && link.code == pmd_pkg::CMD_FLOG_ERASE) begin
         for (int i = 0; i < LOG_BYTES; i++) flog_q[i] <= 8'hff;
      end
   end
   assign link.ack  = s_q.ack;
   assign link.rdata = s_q.rdata;
   // Gain ranges follow the channel 0 mode byte
   assign ilim_high_range = s_q.mode0[pmd_pkg::PWM_ILIM_BIT];
   assign vout_high_range = s_q.mode0[pmd_pkg::PWM_VRANGE_BIT];
   assign cml_fault = s_q.status[pmd_pkg::CML_FAULT_BIT];
   assign log_saved = s_q.saved;
   assign log_erased = s_q.erased;
   assign nvm_mismatch = s_q.mismatch;
   assign reset_pulse = s_q.rst_req;
endmodule

//--- src/pmd_host.sv
`timescale 1ns/1ps
// Host end: software port to single link transactions.
module pmd_host (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Software port
   input  wire logic [1:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [15:0]      rdata,
   // Link
   pmd_link_if.host         link
);
   typedef enum logic [0:0] {PMD_IDLE = 1'b0, PMD_WAIT = 1'b1} pmd_st_t;
   typedef struct packed {
      pmd_st_t     st;
      logic [7:0]  code;
      logic [1:0]  kind;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [15:0] rdata;
      logic        refused;
   } pmd_host_t;
   pmd_host_t s_q, s_d;
   logic legal;
   always_comb begin
      // Published writable codes; identity passes so the device flags it
      case (wdata[15:8])
         pmd_pkg::CMD_PAGE, pmd_pkg::CMD_PWM_MODE, pmd_pkg::CMD_IIN_OFFSET,
         pmd_pkg::CMD_IDENTITY, pmd_pkg::CMD_CTRL_CONFIG,
         pmd_pkg::CMD_SENSE_TC, pmd_pkg::CMD_EXT_SLOPE,
         pmd_pkg::CMD_EXT_OFFSET, pmd_pkg::CMD_RAIL_ADDR: legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end
   always_comb begin
      s_d = s_q;
      s_d.rdata = '0;
      if (wr_stb) begin
         if (addr == pmd_pkg::HREG_CMD && s_q.st == PMD_IDLE) begin
            s_d.code = wdata[15:8];
            s_d.kind = wdata[1:0];
         end else if (addr == pmd_pkg::HREG_WDATA) begin
            s_d.wd = wdata;
         end
      end
      if (s_q.st == PMD_IDLE && wr_stb && addr == pmd_pkg::HREG_CMD) begin
         if (s_d.kind == pmd_pkg::KIND_WRITE && !legal) begin
            s_d.refused = 1'b1;
         end else begin
            s_d.refused = 1'b0;
            s_d.st = PMD_WAIT;
         end
      end else if (s_q.st == PMD_WAIT && link.ack) begin
         s_d.st = PMD_IDLE;
         s_d.rd = link.rdata;
      end
      if (rd_stb) begin
         if (addr == pmd_pkg::HREG_CMD) s_d.rdata = {s_q.code, 6'h00, s_q.kind};
         else if (addr == pmd_pkg::HREG_WDATA) s_d.rdata = s_q.wd;
         else if (addr == pmd_pkg::HREG_RDATA) s_d.rdata = s_q.rd;
         else s_d.rdata = {14'h0, s_q.refused, s_q.st == PMD_WAIT};
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   assign link.req = s_q.st == PMD_WAIT;
   assign link.kind = s_q.kind;
   assign link.code = s_q.code;
   assign link.wdata = s_q.wd;
   assign rdata = s_q.rdata;
endmodule

//--- src/pmd_link_if.sv
`timescale 1ns/1ps
interface pmd_link_if;
   logic        req;
   logic [1:0]  kind;
   logic [7:0]  code;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;
   modport host   (output req, kind, code, wdata, input ack, rdata);
   modport device (input req, kind, code, wdata, output ack, rdata);
endinterface

//--- src/pmd_peak.sv
`timescale 1ns/1ps
// Running maximum of a signed linear 5/11 sample with clear.
module pmd_peak (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Samples
   input  wire logic        sample_valid,
   input  wire logic [15:0] sample,
   input  wire logic        clear,
   // Peak
   output logic [15:0]      peak_q
);
   logic [15:0] peak_d;
   // Mantissa scaled by exponent into a comparable value
   function automatic logic signed [47:0] l11_val(input logic [15:0] w);
      logic signed [4:0]  e;
      logic signed [47:0] m;
      e = w[pmd_pkg::L11_EXP_MSB:pmd_pkg::L11_EXP_LSB];
      m = 48'(signed'(w[pmd_pkg::L11_MAN_MSB:0])) <<< 16;
      l11_val = e[4] ? (m >>> (5'(-e))) : (m <<< e[3:0]);
   endfunction
   always_comb begin
      peak_d = peak_q;
      if (clear) begin
         peak_d = pmd_pkg::RST_DIE_PEAK;
      end else if (sample_valid &&
          (peak_q == pmd_pkg::RST_DIE_PEAK ||
           l11_val(sample) > l11_val(peak_q))) begin
         peak_d = sample;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         peak_q <= pmd_pkg::RST_DIE_PEAK;
      end else if (ce) begin
         peak_q <= peak_d;
      end
   end
endmodule

//--- src/pmd_pkg.sv
package pmd_pkg;
   // -----------------------------------------------------------------
   // Command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_PAGE           = 8'h00;
   localparam logic [7:0] CMD_STORE_ALL      = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL    = 8'h16;
   localparam logic [7:0] CMD_PWM_MODE       = 8'hd4;
   localparam logic [7:0] CMD_PEAK_CLEAR     = 8'he3;
   localparam logic [7:0] CMD_IDENTITY       = 8'he7;
   localparam logic [7:0] CMD_IIN_OFFSET     = 8'he9;
   localparam logic [7:0] CMD_FLOG_SAVE      = 8'hea;
   localparam logic [7:0] CMD_FLOG_ERASE     = 8'hec;
   localparam logic [7:0] CMD_CHAN_IIN       = 8'hed;
   localparam logic [7:0] CMD_FLOG_BYTES     = 8'hee;
   localparam logic [7:0] CMD_SHARED_STATUS  = 8'hef;
   localparam logic [7:0] CMD_NVM_COMPARE    = 8'hf0;
   localparam logic [7:0] CMD_DIE_PEAK       = 8'hf4;
   localparam logic [7:0] CMD_CTRL_CONFIG    = 8'hf5;
   localparam logic [7:0] CMD_SENSE_TC       = 8'hf6;
   localparam logic [7:0] CMD_EXT_SLOPE      = 8'hf8;
   localparam logic [7:0] CMD_EXT_OFFSET     = 8'hf9;
   localparam logic [7:0] CMD_RAIL_ADDR      = 8'hfa;
   localparam logic [7:0] CMD_SOFT_RESET     = 8'hfd;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_IIN_OFFSET    = 16'h9333;
   localparam logic [7:0]  RST_CTRL_CONFIG   = 8'h10;
   localparam logic [15:0] RST_SENSE_TC      = 16'h0f3c;
   localparam logic [15:0] RST_EXT_SLOPE     = 16'h4000;
   localparam logic [15:0] RST_EXT_OFFSET    = 16'h8000;
   localparam logic [7:0]  RST_RAIL_ADDR     = 8'h80;
   localparam logic [7:0]  RST_PWM_MODE      = 8'hc1;
   localparam logic [15:0] RST_DIE_PEAK      = 16'h8000;
   // -----------------------------------------------------------------
   // Field positions and formats
   // -----------------------------------------------------------------
   localparam int L11_EXP_MSB  = 15;
   localparam int L11_EXP_LSB  = 11;
   localparam int L11_MAN_MSB  = 10;
   localparam logic signed [4:0] L16_EXP = 5'sh14; // -12, fixed
   localparam int CML_FAULT_BIT  = 6;
   localparam int PWM_ILIM_BIT   = 7;
   localparam int PWM_VRANGE_BIT = 1;
   // Host register map
   localparam logic [1:0] HREG_CMD    = 2'h0; // [15:8] code [1:0] kind
   localparam logic [1:0] HREG_WDATA  = 2'h1;
   localparam logic [1:0] HREG_RDATA  = 2'h2;
   localparam logic [1:0] HREG_STATUS = 2'h3;
   localparam logic [1:0] KIND_SEND  = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_READ  = 2'h2;
   // Device status bits
   localparam int ST_BUSY = 0;
   localparam int ST_MISMATCH = 1;
   localparam int ST_LOG_SAVED = 2;
   localparam int ST_LOG_ERASED = 3;
endpackage

//--- verification/pmbus_mfr_command_decoder_test.sv
`timescale 1ns/1ps
module pmbus_mfr_command_decoder_test;
   localparam logic [15:0] ID_WORD = 16'h1234; // arbitrary value
   logic        core_clk, rst, wr_stb, rd_stb, die_temp_valid, pulse_seen;
   logic        ilim_high_range, vout_high_range, cml_fault, ce;
   logic        log_saved, log_erased, nvm_mismatch, reset_pulse;
   logic [1:0]  addr;
   logic [15:0] wdata, rdata, die_temp, iin_ch1, d;
   logic [15:0] samp [3] = '{16'h0010, 16'h0030, 16'h0020};
   int          err_count, check_count;
   pmd_link_if link ();
   pmd_host i_pmd_host (.core_clk(core_clk), .rst(rst), .ce(ce),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .link(link));
   pmd_device #(.IDENTITY(ID_WORD)) i_pmd_device (.core_clk(core_clk),
      .rst(rst), .ce(ce), .link(link), .die_temp_valid(die_temp_valid),
      .die_temp(die_temp), .iin_raw_ch0(16'h9005), .iin_raw_ch1(iin_ch1),
      .fault_ram_byte(8'h00), .ilim_high_range(ilim_high_range),
      .vout_high_range(vout_high_range), .cml_fault(cml_fault),
      .log_saved(log_saved), .log_erased(log_erased),
      .nvm_mismatch(nvm_mismatch), .reset_pulse(reset_pulse));
   pmd_link_chk #(.IDENTITY(ID_WORD)) i_pmd_link_chk (.core_clk(core_clk),
      .rst(rst), .req(link.req), .kind(link.kind), .code(link.code),
      .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
   // ----------------------------------------------------------------
   // Clock, pulse catcher, watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (reset_pulse === 1'b1) pulse_seen <= 1'b1;
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic check(input string n, input logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] v);
      @(posedge core_clk);
      addr   <= a;
      wdata  <= v;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] v);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      @(negedge core_clk);
      v = rdata;
   endtask
   // Status is polled, so a slow device never hangs the bench
   task automatic cmd(input logic [1:0] k, input logic [7:0] c,
                      input logic [15:0] v);
      logic [15:0] s;
      s = 16'h0001;
      wr(pmd_pkg::HREG_WDATA, v);
      wr(pmd_pkg::HREG_CMD, {c, 6'h00, k});
      for (int i = 0; i < 40 && s[0] !== 1'b0; i++) rd(pmd_pkg::HREG_STATUS, s);
      check("host idle", 16'(s[0]), 16'h0000);
   endtask
   task automatic send(input logic [7:0] c);
      cmd(pmd_pkg::KIND_SEND, c, 16'h0000);
   endtask
   task automatic put(input logic [7:0] c, input logic [15:0] v);
      cmd(pmd_pkg::KIND_WRITE, c, v);
   endtask
   task automatic get(input logic [7:0] c, output logic [15:0] v);
      cmd(pmd_pkg::KIND_READ, c, 16'h0000);
      rd(pmd_pkg::HREG_RDATA, v);
   endtask
   task automatic expect_reg(input string n, input logic [7:0] c,
                             input logic [15:0] e);
      logic [15:0] v;
      get(c, v);
      check(n, v, e);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1; addr = 2'h0; wdata = 16'h0000; wr_stb = 1'b0;
      rd_stb = 1'b0; die_temp_valid = 1'b0; die_temp = 16'h0000;
      iin_ch1 = 16'h9001; pulse_seen = 1'b0; err_count = 0; check_count = 0;
      ce = 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      expect_reg("iin offset", pmd_pkg::CMD_IIN_OFFSET, 16'h9333);
      expect_reg("sense tc", pmd_pkg::CMD_SENSE_TC, 16'h0f3c);
      expect_reg("ext slope", pmd_pkg::CMD_EXT_SLOPE, 16'h4000);
      expect_reg("ext offset", pmd_pkg::CMD_EXT_OFFSET, 16'h8000);
      expect_reg("rail addr", pmd_pkg::CMD_RAIL_ADDR, 16'h0080);
      expect_reg("ctrl config", pmd_pkg::CMD_CTRL_CONFIG, 16'h0010);
      expect_reg("identity", pmd_pkg::CMD_IDENTITY, ID_WORD);
      check("ilim range", 16'(ilim_high_range), 16'h0001);
      check("vout range", 16'(vout_high_range), 16'h0000);
      wr(pmd_pkg::HREG_WDATA, 16'h0055);
      ce <= 1'b0;
      wr(pmd_pkg::HREG_WDATA, 16'h00aa);
      ce <= 1'b1;
      rd(pmd_pkg::HREG_WDATA, d);
      check("ce hold", d, 16'h0055);
      $display("test defaults done");
      put(pmd_pkg::CMD_PWM_MODE, 16'h0002);
      check("ilim low", 16'(ilim_high_range), 16'h0000);
      check("vout high", 16'(vout_high_range), 16'h0001);
      put(pmd_pkg::CMD_PWM_MODE, 16'h0080);
      check("ilim high", 16'(ilim_high_range), 16'h0001);
      check("vout low", 16'(vout_high_range), 16'h0000);
      $display("test range bits done");
      put(pmd_pkg::CMD_PAGE, 16'h0001);
      put(pmd_pkg::CMD_RAIL_ADDR, 16'h0033);
      expect_reg("rail page1", pmd_pkg::CMD_RAIL_ADDR, 16'h0033);
      expect_reg("iin ch1", pmd_pkg::CMD_CHAN_IIN, 16'h9334);
      put(pmd_pkg::CMD_PAGE, 16'h0000);
      expect_reg("rail page0", pmd_pkg::CMD_RAIL_ADDR, 16'h0080);
      expect_reg("iin ch0", pmd_pkg::CMD_CHAN_IIN, 16'h9338);
      $display("test paging done");
      foreach (samp[i]) begin
         @(posedge core_clk);
         die_temp       <= samp[i];
         die_temp_valid <= 1'b1;
      end
      @(posedge core_clk);
      die_temp_valid <= 1'b0;
      expect_reg("die peak", pmd_pkg::CMD_DIE_PEAK, 16'h0030);
      send(pmd_pkg::CMD_PEAK_CLEAR);
      expect_reg("peak cleared", pmd_pkg::CMD_DIE_PEAK, 16'h8000);
      $display("test peak done");
      expect_reg("unlisted read", 8'heb, 16'h0000);
      check("no fault on read", 16'(cml_fault), 16'h0000);
      put(8'he8, 16'h1111);
      rd(pmd_pkg::HREG_STATUS, d);
      check("refused flag", d & 16'h0002, 16'h0002);
      check("no fault refused", 16'(cml_fault), 16'h0000);
      put(pmd_pkg::CMD_IDENTITY, 16'h1111);
      check("comm fault", 16'(cml_fault), 16'h0001);
      get(pmd_pkg::CMD_SHARED_STATUS, d);
      check("status bit6", d & 16'h0040, 16'h0040);
      $display("test unlisted done");
      send(pmd_pkg::CMD_FLOG_SAVE);
      check("log saved", 16'(log_saved), 16'h0001);
      send(pmd_pkg::CMD_FLOG_ERASE);
      check("log erased", 16'(log_erased), 16'h0001);
      expect_reg("log blank", pmd_pkg::CMD_FLOG_BYTES, 16'h00ff);
      send(pmd_pkg::CMD_STORE_ALL);
      send(pmd_pkg::CMD_NVM_COMPARE);
      check("nvm match", 16'(nvm_mismatch), 16'h0000);
      put(pmd_pkg::CMD_SENSE_TC, 16'h1111);
      send(pmd_pkg::CMD_NVM_COMPARE);
      check("nvm differ", 16'(nvm_mismatch), 16'h0001);
      send(pmd_pkg::CMD_RESTORE_ALL);
      expect_reg("tc restored", pmd_pkg::CMD_SENSE_TC, 16'h0f3c);
      $display("test nvm done");
      put(pmd_pkg::CMD_SENSE_TC, 16'h2222);
      send(pmd_pkg::CMD_FLOG_SAVE);
      send(pmd_pkg::CMD_SOFT_RESET);
      check("reset pulse", 16'(pulse_seen), 16'h0001);
      check("fault cleared", 16'(cml_fault), 16'h0000);
      check("saved cleared", 16'(log_saved), 16'h0000);
      expect_reg("tc reloaded", pmd_pkg::CMD_SENSE_TC, 16'h0f3c);
      $display("test soft reset done");
      final_report();
   end
endmodule

//--- verification/pmd_link_chk.sv
`timescale 1ns/1ps
module pmd_link_chk #(
   parameter logic [15:0] IDENTITY = 16'h5a5a
) (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Link
   input wire logic        req,
   input wire logic [1:0]  kind,
   input wire logic [7:0]  code,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic [15:0] rdata
);
   // ----------------------------------------------------------------
   // Published code decode
   // ----------------------------------------------------------------
   logic known;
   always_comb begin
      case (code)
         pmd_pkg::CMD_PAGE, pmd_pkg::CMD_STORE_ALL, pmd_pkg::CMD_RESTORE_ALL,
         pmd_pkg::CMD_PWM_MODE, pmd_pkg::CMD_PEAK_CLEAR,
         pmd_pkg::CMD_IDENTITY, pmd_pkg::CMD_IIN_OFFSET,
         pmd_pkg::CMD_FLOG_SAVE, pmd_pkg::CMD_FLOG_ERASE,
         pmd_pkg::CMD_CHAN_IIN, pmd_pkg::CMD_FLOG_BYTES,
         pmd_pkg::CMD_SHARED_STATUS, pmd_pkg::CMD_NVM_COMPARE,
         pmd_pkg::CMD_DIE_PEAK, pmd_pkg::CMD_CTRL_CONFIG,
         pmd_pkg::CMD_SENSE_TC, pmd_pkg::CMD_EXT_SLOPE,
         pmd_pkg::CMD_EXT_OFFSET, pmd_pkg::CMD_RAIL_ADDR,
         pmd_pkg::CMD_SOFT_RESET: known = 1'b1;
         default:                 known = 1'b0;
      endcase
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_take;
      req && !ack;
   endsequence
   sequence s_read;
      s_take ##0 kind == pmd_pkg::KIND_READ;
   endsequence
   chk_ack_after_take: assert property (s_take |=> ack)
      else $error("link request not answered next cycle");
   chk_ack_single: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   chk_ack_needs_req: assert property (ack |-> req)
      else $error("link ack without request");
   chk_req_held: assert property (s_take |=> req && $stable(kind)
      && $stable(code) && $stable(wdata))
      else $error("link request changed before ack");
   chk_req_release: assert property (ack |=> !req)
      else $error("link request not dropped after ack");
   chk_rdata_holds: assert property ($changed(rdata) |-> ack)
      else $error("link read data changed outside an answer");
   chk_ident_word: assert property (
      s_read ##0 code == pmd_pkg::CMD_IDENTITY |=> rdata == IDENTITY)
      else $error("identity word wrong");
   chk_unlisted_zero: assert property (s_read ##0 !known
      |=> rdata == 16'h0000)
      else $error("unlisted read returned data");
   chk_byte_upper: assert property (s_read ##0
      (code == pmd_pkg::CMD_CTRL_CONFIG || code == pmd_pkg::CMD_RAIL_ADDR)
      |=> rdata[15:8] == 8'h00)
      else $error("byte command upper half not zero");
endmodule
